// file: hdl/spc_pkg.sv
package spc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Control register fields.
	localparam int SLEEP_ARM_BIT = 6;
	localparam int MODE_BIT2 = 7;
	localparam int MODE_BIT1 = 5;
	localparam int MODE_BIT0 = 4;

	// Status register fields.
	localparam int STAT_SLEEPING = 0;
	localparam int STAT_ASYNC_UNDEF = 1;
	localparam int STAT_MODE_LSB = 2;

	// ------------------------------------------------------------
	// Sleep modes
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_IDLE = 3'h0;
	localparam logic [2:0] MODE_NOISE = 3'h1;
	localparam logic [2:0] MODE_PDOWN = 3'h2;
	localparam logic [2:0] MODE_PSAVE = 3'h3;
	localparam logic [2:0] MODE_RSVD4 = 3'h4;
	localparam logic [2:0] MODE_RSVD5 = 3'h5;
	localparam logic [2:0] MODE_STBY = 3'h6;
	localparam logic [2:0] MODE_XSTBY = 3'h7;

	// ------------------------------------------------------------
	// Timing counts in core clock cycles
	// ------------------------------------------------------------
	localparam logic [7:0] HALT_CYCLES = 8'h04;
	localparam logic [7:0] STBY_WAKE_CYCLES = 8'h06;
	localparam logic [7:0] STARTUP_DEFAULT = 8'h06;

	// ------------------------------------------------------------
	// Clock gate vector bit positions
	// ------------------------------------------------------------
	localparam int G_CORE = 0;
	localparam int G_PMEM = 1;
	localparam int G_PERIPH = 2;
	localparam int G_CONV = 3;
	localparam int G_ASYNC = 4;
	localparam int G_MAIN_OSC = 5;
	localparam int G_TIMER_OSC = 6;
	localparam int G_WIDTH = 7;

	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_SLEEP = 4'h2,
		ST_START = 4'h4,
		ST_HALT = 4'h8
	} spc_state_t;

endpackage : spc_pkg

// file: hdl/spc_cycle_timer.sv
`timescale 1ns/1ps
module spc_cycle_timer #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic load,
	input wire logic [W-1:0] load_val,
	// Status
	output logic last
);

	logic [W-1:0] cnt_q;

	// A loaded count of N makes last high in the N-th cycle after load.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= load_val;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - W'(1);
		end
	end

	assign last = (cnt_q == W'(1));

endmodule : spc_cycle_timer

// file: hdl/spc_sleep_ctrl.sv
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Sleep entered only when the arm bit is set and the sleep strobe arrives.
// - Mode field at bits 7,5,4 selects idle, noise, down, save, standby.
// - Interrupt wake holds core four cycles after start-up, then resumes.
// - Sleep never alters registers or memory; only clocks are gated.
// - A reset during sleep wakes to the reset vector, not the handler.
// - Idle stops only core and program memory clocks.
// - In idle any enabled interrupt wakes the device.
// - Idle or noise entry with converter enabled starts a conversion.
// - Noise mode also stops the peripheral clock; converter keeps running.
// - Noise wake: conversion, two-wire match, timer, store-ready, ext lines.
// - Power-down stops main oscillator and all generated clocks.
// - Power-down wake: two-wire match, ext level lines a/b, line c.
// - Power-down wake waits the fuse-selected start-up period.
// - Power-save as power-down, plus masked async timer events when async.
// - Power-save without async clock leaves timer contents undefined.
// - Standby: power-down with main oscillator on, six-cycle wake.
// - Extended standby: power-save with main oscillator on, six-cycle wake.
// - Control register is read-write and resets to zero.
// - Power-down and power-save start-up cycles follow the start-up fuse setting.
module spc_sleep_ctrl #(
	parameter int CW = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Core side
	input wire logic sleep_instr,
	input wire logic sys_reset_req,
	output logic core_halt,
	output logic core_resume,
	output logic reset_vector_go,
	// Fuses and straps
	input wire logic xtal_clock_opt,
	input wire logic [CW-1:0] startup_cycles,
	// Wake sources
	input wire logic irq_any,
	input wire logic adc_done_irq,
	input wire logic twi_match_irq,
	input wire logic spm_ready_irq,
	input wire logic ext_level_ab_irq,
	input wire logic ext_c_irq,
	input wire logic timer_ovf_evt,
	input wire logic timer_cmp_evt,
	input wire logic timer_ovf_mask,
	input wire logic timer_cmp_mask,
	input wire logic global_irq_en,
	input wire logic async_timer_clock_sel,
	// Converter
	input wire logic adc_enabled,
	output logic adc_start,
	// Clock gates
	output logic core_clock_en,
	output logic program_mem_clock_en,
	output logic periph_clock_en,
	output logic converter_clock_en,
	output logic async_timer_clock_en,
	output logic main_osc_en,
	output logic timer_osc_en
);

	// ------------------------------------------------------------
	// Control register and mode decode
	// ------------------------------------------------------------
	logic [7:0] ctrl_q;
	logic [2:0] mode_sel;
	logic [2:0] mode_q;
	logic mode_ok;
	logic sleep_go;
	spc_pkg::spc_state_t state_q;
	spc_pkg::spc_state_t state_d;

	assign mode_sel = {ctrl_q[spc_pkg::MODE_BIT2],
		ctrl_q[spc_pkg::MODE_BIT1], ctrl_q[spc_pkg::MODE_BIT0]};

	always_comb begin
		case (mode_sel)
			spc_pkg::MODE_RSVD4,
			spc_pkg::MODE_RSVD5: mode_ok = 1'b0;
			spc_pkg::MODE_STBY,
			spc_pkg::MODE_XSTBY: mode_ok = xtal_clock_opt;
			default: mode_ok = 1'b1;
		endcase
	end

	assign sleep_go = (state_q == spc_pkg::ST_RUN) && sleep_instr &&
		ctrl_q[spc_pkg::SLEEP_ARM_BIT] && mode_ok;

	// ------------------------------------------------------------
	// Wake qualification
	// ------------------------------------------------------------
	logic timer_q_evt;
	logic ext_wake;
	logic wake_hit;

	assign timer_q_evt = global_irq_en &&
		((timer_ovf_evt && timer_ovf_mask) ||
		(timer_cmp_evt && timer_cmp_mask));
	assign ext_wake = twi_match_irq || ext_level_ab_irq || ext_c_irq;

	always_comb begin
		case (mode_q)
			spc_pkg::MODE_IDLE: wake_hit = irq_any;
			spc_pkg::MODE_NOISE: wake_hit = ext_wake || adc_done_irq ||
				spm_ready_irq || timer_q_evt;
			spc_pkg::MODE_PSAVE,
			spc_pkg::MODE_XSTBY: wake_hit = ext_wake ||
				(async_timer_clock_sel && timer_q_evt);
			default: wake_hit = ext_wake;
		endcase
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	logic tmr_load;
	logic [CW-1:0] tmr_val;
	logic tmr_last;
	logic [CW-1:0] startup_n;

	// A zero fuse count would stall the timer, so it is held at one.
	assign startup_n = (startup_cycles == '0) ? CW'(1) : startup_cycles;

	always_comb begin
		state_d = state_q;
		tmr_load = 1'b0;
		tmr_val = CW'(spc_pkg::HALT_CYCLES);
		case (state_q)
			spc_pkg::ST_RUN: begin
				if (sleep_go) begin
					state_d = spc_pkg::ST_SLEEP;
				end
			end
			spc_pkg::ST_SLEEP: begin
				if (wake_hit) begin
					tmr_load = 1'b1;
					case (mode_q)
						spc_pkg::MODE_PDOWN,
						spc_pkg::MODE_PSAVE: begin
							state_d = spc_pkg::ST_START;
							tmr_val = startup_n;
						end
						spc_pkg::MODE_STBY,
						spc_pkg::MODE_XSTBY: begin
							state_d = spc_pkg::ST_START;
							tmr_val = CW'(spc_pkg::STBY_WAKE_CYCLES);
						end
						default: state_d = spc_pkg::ST_HALT;
					endcase
				end
			end
			spc_pkg::ST_START: begin
				if (tmr_last) begin
					tmr_load = 1'b1;
					state_d = spc_pkg::ST_HALT;
				end
			end
			spc_pkg::ST_HALT: begin
				if (tmr_last) begin
					state_d = spc_pkg::ST_RUN;
				end
			end
			default: state_d = spc_pkg::ST_RUN;
		endcase
		if (sys_reset_req) begin
			state_d = spc_pkg::ST_RUN;
		end
	end

	spc_cycle_timer #(
		.W(CW)
	) u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(tmr_load),
		.load_val(tmr_val),
		.last(tmr_last)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= spc_pkg::ST_RUN;
			mode_q <= spc_pkg::MODE_IDLE;
		end else begin
			state_q <= state_d;
			if (sleep_go) begin
				mode_q <= mode_sel;
			end
		end
	end

	// Core and converter strobes; the handler itself is the core's business.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_resume <= 1'b0;
			reset_vector_go <= 1'b0;
			adc_start <= 1'b0;
		end else begin
			core_resume <= (state_q == spc_pkg::ST_HALT) && tmr_last &&
				!sys_reset_req;
			reset_vector_go <= sys_reset_req &&
				(state_q != spc_pkg::ST_RUN);
			adc_start <= sleep_go && adc_enabled &&
				(mode_sel == spc_pkg::MODE_IDLE ||
				mode_sel == spc_pkg::MODE_NOISE);
		end
	end

	assign core_halt = (state_q != spc_pkg::ST_RUN);

	// ------------------------------------------------------------
	// Clock gating
	// ------------------------------------------------------------
	logic [spc_pkg::G_WIDTH-1:0] gate_d;
	logic [spc_pkg::G_WIDTH-1:0] gate_q;
	logic as_sel;

	assign as_sel = async_timer_clock_sel;

	// Gates are computed from the next state so they change with it.
	// Registers and memory stay powered; only their clocks stop.
	always_comb begin
		gate_d = '0;
		gate_d[spc_pkg::G_TIMER_OSC] = as_sel;
		case (state_d)
			spc_pkg::ST_SLEEP: begin
				case (mode_sel_eff(state_q, mode_sel, mode_q))
					spc_pkg::MODE_IDLE: begin
						gate_d[spc_pkg::G_PERIPH] = 1'b1;
						gate_d[spc_pkg::G_CONV] = 1'b1;
						gate_d[spc_pkg::G_ASYNC] = 1'b1;
						gate_d[spc_pkg::G_MAIN_OSC] = 1'b1;
					end
					spc_pkg::MODE_NOISE: begin
						gate_d[spc_pkg::G_CONV] = 1'b1;
						gate_d[spc_pkg::G_ASYNC] = 1'b1;
						gate_d[spc_pkg::G_MAIN_OSC] = 1'b1;
					end
					spc_pkg::MODE_PSAVE: begin
						gate_d[spc_pkg::G_ASYNC] = as_sel;
					end
					spc_pkg::MODE_STBY: begin
						gate_d[spc_pkg::G_MAIN_OSC] = 1'b1;
						gate_d[spc_pkg::G_TIMER_OSC] = 1'b0;
					end
					spc_pkg::MODE_XSTBY: begin
						gate_d[spc_pkg::G_ASYNC] = as_sel;
						gate_d[spc_pkg::G_MAIN_OSC] = 1'b1;
					end
					default: begin
						gate_d[spc_pkg::G_TIMER_OSC] = 1'b0;
					end
				endcase
			end
			spc_pkg::ST_START: begin
				gate_d[spc_pkg::G_MAIN_OSC] = 1'b1;
				gate_d[spc_pkg::G_ASYNC] = as_sel;
			end
			spc_pkg::ST_HALT: begin
				gate_d = {as_sel, 1'b1, as_sel, 3'h7, 1'b0};
			end
			default: begin
				gate_d = {as_sel, 1'b1, as_sel, 4'hF};
			end
		endcase
	end

	function automatic logic [2:0] mode_sel_eff(
		input spc_pkg::spc_state_t st,
		input logic [2:0] live, input logic [2:0] held);
		mode_sel_eff = (st == spc_pkg::ST_RUN) ? live : held;
	endfunction : mode_sel_eff

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gate_q <= {1'b0, 1'b1, 1'b0, 4'hF};
		end else begin
			gate_q <= gate_d;
		end
	end

	assign core_clock_en = gate_q[spc_pkg::G_CORE];
	assign program_mem_clock_en = gate_q[spc_pkg::G_PMEM];
	assign periph_clock_en = gate_q[spc_pkg::G_PERIPH];
	assign converter_clock_en = gate_q[spc_pkg::G_CONV];
	assign async_timer_clock_en = gate_q[spc_pkg::G_ASYNC];
	assign main_osc_en = gate_q[spc_pkg::G_MAIN_OSC];
	assign timer_osc_en = gate_q[spc_pkg::G_TIMER_OSC];

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic aw_have_q;
	logic w_have_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic do_write;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic async_undef_q;
	logic undef_set;

	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready = !w_have_q && !s_axi_bvalid;
	assign wr_addr = aw_have_q ? aw_addr_q : s_axi_awaddr;
	assign wr_data = w_have_q ? w_data_q : s_axi_wdata;
	assign wr_strb = w_have_q ? w_strb_q : s_axi_wstrb;
	assign do_write = (aw_have_q || (s_axi_awvalid && s_axi_awready)) &&
		(w_have_q || (s_axi_wvalid && s_axi_wready));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (do_write) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_addr == spc_pkg::ADDR_CTRL ||
					wr_addr == spc_pkg::ADDR_STAT) ? 2'h0 : 2'h3;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_have_q <= 1'b1;
					aw_addr_q <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_have_q <= 1'b1;
					w_data_q <= s_axi_wdata;
					w_strb_q <= s_axi_wstrb;
				end
				if (s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end
		end
	end

	// Any core reset also returns the control register to zero.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= spc_pkg::CTRL_RESET;
		end else if (sys_reset_req) begin
			ctrl_q <= spc_pkg::CTRL_RESET;
		end else if (do_write && wr_addr == spc_pkg::ADDR_CTRL &&
			wr_strb[0]) begin
			ctrl_q <= wr_data[7:0];
		end
	end

	// Set wins over a clear in the same cycle.
	assign undef_set = (state_q == spc_pkg::ST_SLEEP) && wake_hit &&
		(mode_q == spc_pkg::MODE_PSAVE) && !async_timer_clock_sel;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			async_undef_q <= 1'b0;
		end else if (undef_set) begin
			async_undef_q <= 1'b1;
		end else if (do_write && wr_addr == spc_pkg::ADDR_STAT &&
			wr_strb[0] && wr_data[spc_pkg::STAT_ASYNC_UNDEF]) begin
			async_undef_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			case (s_axi_araddr)
				spc_pkg::ADDR_CTRL: s_axi_rdata <= {24'h000000, ctrl_q};
				spc_pkg::ADDR_STAT: s_axi_rdata <= {27'h0, mode_q,
					async_undef_q, core_halt};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'h3;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	assign s_axi_arready = !s_axi_rvalid;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_unarmed_no_sleep: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(state_q == spc_pkg::ST_RUN && sleep_instr &&
		!ctrl_q[spc_pkg::SLEEP_ARM_BIT]) |=> state_q == spc_pkg::ST_RUN)
		else $error("sleep entered while disarmed");

	chk_reserved_refused: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(state_q == spc_pkg::ST_RUN && !mode_ok) |=>
		state_q == spc_pkg::ST_RUN)
		else $error("sleep entered with refused mode");

	chk_halt_four: assert property (
		@(posedge aclk) disable iff (!aresetn || sys_reset_req)
		$rose(state_q == spc_pkg::ST_HALT) |->
		(state_q == spc_pkg::ST_HALT)[*4] ##1
		(core_resume && state_q == spc_pkg::ST_RUN))
		else $error("halt length wrong");

	chk_idle_gates: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(state_q == spc_pkg::ST_SLEEP && mode_q == spc_pkg::MODE_IDLE) |->
		(!core_clock_en && !program_mem_clock_en && periph_clock_en &&
		converter_clock_en))
		else $error("idle gating wrong");

	chk_pdown_gates: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(state_q == spc_pkg::ST_SLEEP && mode_q == spc_pkg::MODE_PDOWN) |->
		(gate_q == '0))
		else $error("power-down gating wrong");

	chk_reset_wake: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(sys_reset_req && state_q != spc_pkg::ST_RUN) |=>
		(reset_vector_go && state_q == spc_pkg::ST_RUN && !core_resume))
		else $error("reset during sleep mishandled");

	chk_adc_start: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(sleep_go && adc_enabled && mode_sel == spc_pkg::MODE_NOISE) |=>
		(adc_start && state_q == spc_pkg::ST_SLEEP))
		else $error("conversion not started");

	chk_standby_six: assert property (
		@(posedge aclk) disable iff (!aresetn || sys_reset_req)
		($rose(state_q == spc_pkg::ST_START) &&
		mode_q == spc_pkg::MODE_STBY) |->
		(state_q == spc_pkg::ST_START)[*6] ##1
		(state_q == spc_pkg::ST_HALT))
		else $error("standby wake length wrong");

endmodule : spc_sleep_ctrl

// file: bench/spc_core_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Processor core as seen by the power controller
// ------------------------------------------------------------
module spc_core_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Controller side
	input wire logic core_halt,
	input wire logic reset_vector_go,
	output logic sleep_instr
);
	int n_rvec;

	initial sleep_instr = 1'b0;

	// A halted core fetches nothing, so it cannot issue another strobe.
	task automatic exec_sleep();
		@(posedge aclk);
		if (!core_halt) sleep_instr <= 1'b1;
		@(posedge aclk);
		sleep_instr <= 1'b0;
	endtask : exec_sleep

	always_ff @(posedge aclk) begin
		if (!aresetn) n_rvec <= 0;
		else if (reset_vector_go) n_rvec <= n_rvec + 1;
	end
endmodule : spc_core_model

// file: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic aclk, aresetn, sys_reset_req, xtal_clock_opt, async_timer_clock_sel;
	logic [7:0] s_axi_awaddr, s_axi_araddr, startup_cycles, wk, rv;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, gie, adc_en;
	logic [31:0] s_axi_wdata;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire logic s_axi_rvalid, sleep_instr, core_halt, core_resume, adc_start;
	wire logic reset_vector_go;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [6:0] gates;
	int cyc, wake_t, error_cnt, n_compared;
	logic [33:0] q_rd[$];
	logic [33:0] q_lat[$];
	logic [33:0] q_wr[$];
	logic [6:0] gx [8] = '{7'h7C, 7'h78, 7'h00, 7'h50, 7'h00, 7'h00, 7'h20,
		7'h70};
	logic [7:0] rj [8] = '{8'h00, 8'h01, 8'hCB, 8'h0B, 8'h00, 8'h00, 8'hCB,
		8'h0B};
	int sx [8] = '{0, 1, 4, 6, 0, 0, 2, 7};

	spc_sleep_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_instr,
		.sys_reset_req, .core_halt, .core_resume, .reset_vector_go,
		.xtal_clock_opt, .startup_cycles, .irq_any(wk[0]),
		.adc_done_irq(wk[1]), .twi_match_irq(wk[2]), .spm_ready_irq(wk[3]),
		.ext_level_ab_irq(wk[4]), .ext_c_irq(wk[5]), .timer_ovf_evt(wk[6]),
		.timer_cmp_evt(wk[7]), .timer_ovf_mask(1'b1), .timer_cmp_mask(1'b1),
		.global_irq_en(gie), .async_timer_clock_sel, .adc_enabled(adc_en),
		.adc_start, .core_clock_en(gates[0]), .program_mem_clock_en(gates[1]),
		.periph_clock_en(gates[2]), .converter_clock_en(gates[3]),
		.async_timer_clock_en(gates[4]), .main_osc_en(gates[5]),
		.timer_osc_en(gates[6]));

	spc_core_model u_core (.aclk, .aresetn, .core_halt, .reset_vector_go,
		.sleep_instr);

	// ------------------------------------------------------------
	// Checking
	// ------------------------------------------------------------
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : finish_test

	initial aclk = 1'b0;
	always #5 aclk = ~aclk;

	// Wake latency is counted in edges from the one that raises the source.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata},
			q_rd.pop_front());
		if (s_axi_bvalid && s_axi_bready) check(34'(s_axi_bresp),
			q_wr.pop_front());
		if (core_resume) check(34'(cyc - wake_t), q_lat.pop_front());
		if (cyc == 5000) begin
			error_cnt++;
			finish_test();
		end
	end

	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		q_wr.push_back(34'h0);
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while ((s_axi_awvalid && !s_axi_awready) ||
			(s_axi_wvalid && !s_axi_wready));
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, input logic [33:0] e);
		@(posedge aclk);
		q_rd.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : axi_read

	function automatic logic [7:0] ctrl(input logic [2:0] m, input logic arm);
		return {m[2], arm, m[1:0], 4'h0};
	endfunction : ctrl

	// Wrong sources are offered first; only the mode's own source may wake.
	task automatic do_sleep(input logic [2:0] m, input logic [6:0] g,
		input int s, input int src, input logic [7:0] rej);
		adc_en <= m[0];
		axi_write(spc_pkg::ADDR_CTRL, 32'(ctrl(m, 1'b1)));
		u_core.exec_sleep();
		#1;
		check(34'(core_halt), 34'h1);
		check(34'(adc_start), 34'(m < 3'h2 && adc_en));
		check(34'(gates), 34'(g));
		@(posedge aclk);
		wk <= rej | 8'hC0;
		gie <= 1'b0;
		repeat (4) @(posedge aclk);
		check(34'(core_halt), 34'h1);
		wk <= 8'(1 << src);
		gie <= 1'b1;
		wake_t = cyc;
		q_lat.push_back(34'(2 + s) + 34'(spc_pkg::HALT_CYCLES));
		do @(posedge aclk); while (!core_resume);
		wk <= 8'h00;
		axi_write(spc_pkg::ADDR_CTRL, 32'h0);
	endtask : do_sleep

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		{aresetn, sys_reset_req, wk, rv, cyc, wake_t} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, error_cnt, n_compared} = '0;
		xtal_clock_opt = 1'b1;
		{gie, adc_en} = 2'h3;
		async_timer_clock_sel = 1'b1;
		void'($urandom(32'h9249C616));
		startup_cycles = 8'(2 + $urandom % 10);
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(spc_pkg::ADDR_CTRL, 34'h0);
		rv = 8'($urandom);
		axi_write(spc_pkg::ADDR_CTRL, 32'(rv));
		axi_read(spc_pkg::ADDR_CTRL, 34'(rv));
		axi_read(8'h08, {2'b11, 32'h0});
		for (int m = 0; m < 10; m++) begin
			if (m < 8 && m != 4 && m != 5) do_sleep(3'(m), gx[m],
				m < 2 ? 0 : m < 4 ? int'(startup_cycles) :
				int'(spc_pkg::STBY_WAKE_CYCLES), sx[m], rj[m]);
			else begin
				axi_write(spc_pkg::ADDR_CTRL, 32'(ctrl(3'(m == 9 ? 2 :
					m == 8 ? 6 : m), m != 9)));
				xtal_clock_opt <= (m != 8);
				u_core.exec_sleep();
				#1;
				check(34'(core_halt), 34'h0);
				check(34'(gates), 34'h7F);
			end
		end
		async_timer_clock_sel <= 1'b0;
		do_sleep(spc_pkg::MODE_PSAVE, 7'h00, int'(startup_cycles), 5, 8'hC0);
		axi_read(spc_pkg::ADDR_STAT, 34'h0E);
		axi_write(spc_pkg::ADDR_STAT, 32'h2);
		axi_read(spc_pkg::ADDR_STAT, 34'h0C);
		axi_write(spc_pkg::ADDR_CTRL, 32'(ctrl(spc_pkg::MODE_PDOWN, 1'b1)));
		u_core.exec_sleep();
		repeat (3) @(posedge aclk);
		sys_reset_req <= 1'b1;
		@(posedge aclk);
		sys_reset_req <= 1'b0;
		repeat (3) @(posedge aclk);
		check(34'(u_core.n_rvec), 34'h1);
		check(34'(core_halt), 34'h0);
		axi_read(spc_pkg::ADDR_CTRL, 34'h0);
		@(posedge aclk);
		check(34'(q_rd.size() + q_lat.size() + q_wr.size()), 34'h0);
		finish_test();
	end
endmodule : tb_top
